/* rtl/qdlc_pkg.sv */
// Shared constants and carrier types for the quad converter load control
package qdlc_pkg;

    // ------------------------------------------------------------------
    // Channel and code geometry
    // ------------------------------------------------------------------
    localparam int NUM_CH = 4;           // Channels A..D
    localparam int SEL_W = 2;            // Channel address width
    localparam int CODE_W = 8;           // Converter code width
    localparam int FRAME_BITS = 12;      // Serial frame length

    // ------------------------------------------------------------------
    // Serial frame field positions, first bit sent sits highest
    // ------------------------------------------------------------------
    localparam int SHUT_ALL_POS = 11;    // shutdown_all_bit, low shuts all
    localparam int SHUT_SEL_POS = 10;    // shutdown_selected_bit, low active
    localparam int SEL_HI_POS = 9;       // channel_sel_hi
    localparam int SEL_LO_POS = 8;       // channel_sel_lo
    localparam int CODE_MSB_POS = 7;     // Top of frame_code_bits

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] ZERO_CODE = 8'h00;
    localparam logic [FRAME_BITS-1:0] CHAIN_RESET = 12'h000;
    localparam logic [NUM_CH-1:0] SHUT_NONE = 4'h0;
    localparam logic [NUM_CH-1:0] SHUT_EVERY = 4'hF;

    // ------------------------------------------------------------------
    // Channel addresses
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] CH_A = 2'h0;
    localparam logic [SEL_W-1:0] CH_B = 2'h1;
    localparam logic [SEL_W-1:0] CH_C = 2'h2;
    localparam logic [SEL_W-1:0] CH_D = 2'h3;

    // Pin bundle as seen by the system clock after synchronising
    typedef struct packed {
        logic clear_n;                   // Clears both register sets
        logic load_n;                    // dac_load_strobe_n level
        logic write_n;                   // Parallel write strobe
        logic chip_sel_n;                // Serial chip select
        logic [SEL_W-1:0] sel;           // Parallel channel address
        logic [CODE_W-1:0] code;         // parallel_code_bus
    } qdlc_pins_s;

    // Idle level of every strobe, used as synchroniser reset value
    localparam qdlc_pins_s PINS_IDLE = '{
        clear_n: 1'b1,
        load_n: 1'b1,
        write_n: 1'b1,
        chip_sel_n: 1'b1,
        sel: 2'h0,
        code: 8'h00
    };

    // Bank of per-channel codes
    typedef logic [NUM_CH-1:0][CODE_W-1:0] qdlc_bank_t;

endpackage

/* rtl/qdlc_top.sv */
// Quad converter load control: serial and parallel code loading logic
`timescale 1ns/1ps
module qdlc_top
    import qdlc_pkg::*;
#(
    parameter bit PARALLEL_VARIANT = 1'b0  // 1 selects the parallel front end
)
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic serial_clk_i,
    input wire logic chip_sel_n_i,
    input wire logic serial_in_i,
    input wire logic write_n_i,
    input wire logic channel_sel_hi_i,
    input wire logic channel_sel_lo_i,
    input wire logic [CODE_W-1:0] parallel_code_bus_i,
    input wire logic dac_load_strobe_n_i,
    input wire logic clear_n_i,
    output logic [NUM_CH-1:0][CODE_W-1:0] dac_code_o,
    output logic [NUM_CH-1:0] shutdown_o
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Frame must hold two flags, the address and one code
    if (FRAME_BITS != CODE_W + SEL_W + 2)
    begin : g_bad_frame
        $error("qdlc_top: frame layout does not match code width");
    end
    // Two address bits can only reach four channels
    if (NUM_CH != (1 << SEL_W))
    begin : g_bad_ch
        $error("qdlc_top: channel count does not match address width");
    end

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // One-hot channel mask from a channel address
    function automatic logic [NUM_CH-1:0] chan_mask(
        input logic [SEL_W-1:0] sel
    );
        chan_mask = SHUT_NONE;
        chan_mask[sel] = 1'b1;
    endfunction

    // ------------------------------------------------------------------
    // Link domain: serial_shift_chain on the serial clock
    // ------------------------------------------------------------------
    logic [FRAME_BITS-1:0] serial_shift_chain; // Last twelve bits seen

    // Select and data are timed by the host to this clock, so they are
    // sampled here directly; clear never reaches the chain.
    always_ff @(posedge serial_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            serial_shift_chain <= CHAIN_RESET;
        end
        else if (!chip_sel_n_i)
        begin
            // Newest bit enters low, so the first bit ends highest
            serial_shift_chain <= {serial_shift_chain[FRAME_BITS-2:0],
                                   serial_in_i};
        end
    end

    // ------------------------------------------------------------------
    // Pin synchroniser into the system clock
    // ------------------------------------------------------------------
    qdlc_pins_s pins_raw;   // Pins as they arrive
    qdlc_pins_s sync_a;     // First stage, read only by pin
    qdlc_pins_s pin;        // Second stage, safe to use
    logic cs_prev;          // Select one cycle back, for edge finding

    assign pins_raw = '{
        clear_n: clear_n_i,
        load_n: dac_load_strobe_n_i,
        write_n: write_n_i,
        chip_sel_n: chip_sel_n_i,
        sel: {channel_sel_hi_i, channel_sel_lo_i},
        code: parallel_code_bus_i
    };

    // Two flops per pin; strobes rest at their idle level in reset
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync_a <= PINS_IDLE;
            pin <= PINS_IDLE;
            cs_prev <= 1'b1;
        end
        else
        begin
            sync_a <= pins_raw;
            pin <= sync_a;
            cs_prev <= pin.chip_sel_n;
        end
    end

    // ------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------
    // The chain is only read at a select rise: by then the host has
    // stopped shifting, so the whole word is quiet while it crosses.
    logic cs_rise;                     // Synchronised select went high
    logic frame_take;                  // Serial frame is stored now
    logic [SEL_W-1:0] frame_ch;        // Frame channel address
    logic [CODE_W-1:0] frame_code;     // frame_code_bits
    logic shutdown_all_bit;            // Low: shut all channels
    logic shutdown_selected_bit;       // Low: shut addressed channel
    logic [NUM_CH-1:0] frame_shut;     // Shutdown set a frame asks for

    assign cs_rise = pin.chip_sel_n & ~cs_prev;
    assign frame_take = !PARALLEL_VARIANT && cs_rise;
    assign frame_ch = serial_shift_chain[SEL_HI_POS:SEL_LO_POS];
    assign frame_code = serial_shift_chain[CODE_MSB_POS:0];
    assign shutdown_all_bit = serial_shift_chain[SHUT_ALL_POS];
    assign shutdown_selected_bit = serial_shift_chain[SHUT_SEL_POS];
    // All-off wins over single-off; a frame with both flags high
    // brings every channel back up.
    assign frame_shut = !shutdown_all_bit ? SHUT_EVERY :
                        !shutdown_selected_bit ? chan_mask(frame_ch) :
                        SHUT_NONE;

    // ------------------------------------------------------------------
    // Parallel decode
    // ------------------------------------------------------------------
    logic par_write;                   // Addressed input is transparent
    assign par_write = PARALLEL_VARIANT && !pin.write_n;

    // ------------------------------------------------------------------
    // Input and DAC register banks
    // ------------------------------------------------------------------
    qdlc_bank_t in_reg;                // Input registers A..D
    qdlc_bank_t dac_reg;               // DAC registers A..D
    logic [NUM_CH-1:0] shut;           // Per-channel shutdown
    qdlc_bank_t next_in;
    qdlc_bank_t next_dac;
    logic [NUM_CH-1:0] next_shut;

    // Latch behaviour is emulated by sampling every cycle: a level
    // strobe keeps the register following, its rise stops the update
    // and the last sampled value stays. Latency is the sync depth plus one edge.
    always_comb
    begin
        next_in = in_reg;
        next_dac = dac_reg;
        next_shut = shut;
        if (!pin.clear_n)
        begin
            // Clear overrides every write and load
            next_in = '0;
            next_dac = '0;
        end
        else
        begin
            if (frame_take)
            begin
                next_in[frame_ch] = frame_code;
            end
            if (par_write)
            begin
                next_in[pin.sel] = pin.code;
            end
            if (!pin.load_n)
            begin
                // Uses next_in so a bus write flows straight through
                next_dac = next_in;
            end
        end
        if (frame_take)
        begin
            // Shutdown flags are not part of the cleared registers
            next_shut = frame_shut;
        end
    end

    // Bank state update
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            in_reg <= '0;
            dac_reg <= '0;
            shut <= SHUT_NONE;
        end
        else
        begin
            in_reg <= next_in;
            dac_reg <= next_dac;
            shut <= next_shut;
        end
    end

    // Outputs to the analog section, straight from the flops
    assign dac_code_o = dac_reg;
    assign shutdown_o = shut;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Chain shifts one bit per edge while selected
    property p_shift_adv;
        @(posedge serial_clk_i) disable iff (rst_i)
        !chip_sel_n_i |=> serial_shift_chain ==
            {$past(serial_shift_chain[FRAME_BITS-2:0]),
             $past(serial_in_i)};
    endproperty
    a_shift_adv: assert property (p_shift_adv)
        else $error("shift chain did not advance one bit");

    // Chain ignores the clock when deselected
    property p_shift_hold;
        @(posedge serial_clk_i) disable iff (rst_i)
        chip_sel_n_i |=> $stable(serial_shift_chain);
    endproperty
    a_shift_hold: assert property (p_shift_hold)
        else $error("shift chain moved while deselected");

    // Frame code lands in the addressed input register only
    property p_frame_store;
        @(posedge clock_i) disable iff (rst_i)
        frame_take && pin.clear_n |=>
            in_reg[$past(frame_ch)] == $past(frame_code);
    endproperty
    a_frame_store: assert property (p_frame_store)
        else $error("frame code not stored in addressed register");

    // Channel A address leaves registers B and D unchanged
    property p_addr_a;
        @(posedge clock_i) disable iff (rst_i)
        frame_take && pin.clear_n && frame_ch == CH_A |=>
            in_reg[CH_B] == $past(in_reg[CH_B]) &&
            in_reg[CH_D] == $past(in_reg[CH_D]);
    endproperty
    a_addr_a: assert property (p_addr_a)
        else $error("channel A frame disturbed another register");

    // Channel D address leaves registers A and C unchanged
    property p_addr_d;
        @(posedge clock_i) disable iff (rst_i)
        frame_take && pin.clear_n && frame_ch == CH_D |=>
            in_reg[CH_A] == $past(in_reg[CH_A]) &&
            in_reg[CH_C] == $past(in_reg[CH_C]);
    endproperty
    a_addr_d: assert property (p_addr_d)
        else $error("channel D frame disturbed another register");

    // Shutdown flags move only when a frame is stored
    property p_shut_keep;
        @(posedge clock_i) disable iff (rst_i)
        !frame_take |=> $stable(shutdown_o);
    endproperty
    a_shut_keep: assert property (p_shut_keep)
        else $error("shutdown flags changed without a frame");

    // Low shutdown-all bit shuts every channel
    property p_shut_all;
        @(posedge clock_i) disable iff (rst_i)
        frame_take && !shutdown_all_bit |=> shutdown_o == SHUT_EVERY;
    endproperty
    a_shut_all: assert property (p_shut_all)
        else $error("shutdown-all did not shut every channel");

    // Low shutdown-selected bit shuts only the addressed channel
    property p_shut_sel;
        @(posedge clock_i) disable iff (rst_i)
        frame_take && shutdown_all_bit && !shutdown_selected_bit |=>
            shutdown_o == chan_mask($past(frame_ch));
    endproperty
    a_shut_sel: assert property (p_shut_sel)
        else $error("shutdown-selected hit the wrong channels");

    // Load low makes the DAC bank mirror the input bank
    property p_load_follow;
        @(posedge clock_i) disable iff (rst_i)
        !pin.load_n && pin.clear_n |=> dac_reg == in_reg;
    endproperty
    a_load_follow: assert property (p_load_follow)
        else $error("DAC bank not following inputs under load");

    // Load high freezes the DAC bank
    property p_load_hold;
        @(posedge clock_i) disable iff (rst_i)
        pin.load_n && pin.clear_n |=> $stable(dac_reg);
    endproperty
    a_load_hold: assert property (p_load_hold)
        else $error("DAC bank changed with load strobe high");

    // Clear zeroes both banks but leaves the chain
    property p_clear;
        @(posedge clock_i) disable iff (rst_i)
        !pin.clear_n |=> in_reg == '0 && dac_reg == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero the register banks");

    // Parallel write low passes the bus into the addressed register
    property p_par_pass;
        @(posedge clock_i) disable iff (rst_i)
        par_write && pin.clear_n |=>
            in_reg[$past(pin.sel)] == $past(pin.code);
    endproperty
    a_par_pass: assert property (p_par_pass)
        else $error("parallel bus not passed to addressed register");

    // Write and load low: bus value reaches the addressed DAC register
    property p_flow;
        @(posedge clock_i) disable iff (rst_i)
        par_write && !pin.load_n && pin.clear_n |=>
            dac_reg[$past(pin.sel)] == $past(pin.code);
    endproperty
    a_flow: assert property (p_flow)
        else $error("bus value did not flow to the DAC register");

    // Write high, load low: inputs hold while the DAC bank follows
    property p_wr_hi_load;
        @(posedge clock_i) disable iff (rst_i)
        pin.write_n && !pin.load_n && pin.clear_n && !frame_take |=>
            $stable(in_reg) && dac_reg == in_reg;
    endproperty
    a_wr_hi_load: assert property (p_wr_hi_load)
        else $error("inputs moved or DAC bank lagged with write high");

    // Both strobes high leave both banks alone
    property p_idle;
        @(posedge clock_i) disable iff (rst_i)
        pin.write_n && pin.load_n && pin.clear_n && !frame_take |=>
            $stable(in_reg) && $stable(dac_reg);
    endproperty
    a_idle: assert property (p_idle)
        else $error("registers changed with both strobes high");

endmodule

/* bench/qdlc_host_model.sv */
// Host model that shifts serial frames into the converter front end
`timescale 1ns/1ps
module qdlc_host_model
    import qdlc_pkg::*;
(
    output logic serial_clk_o,
    output logic chip_sel_n_o,
    output logic serial_in_o
);
    // ------------------------------------------------------------
    // Idle state: link clock stands low, select high
    // ------------------------------------------------------------
    initial
    begin
        serial_clk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        serial_in_o = 1'b0;
    end

    // Send the top nbits of a frame, first bit highest; zero bits
    // gives a bare select pulse that re-stores the chain
    task automatic send_frame(input logic [FRAME_BITS-1:0] frame,
                              input int nbits, input int half);
        chip_sel_n_o = 1'b0;
        #(half);
        for (int i = FRAME_BITS - 1; i >= FRAME_BITS - nbits; i--)
        begin
            serial_in_o = frame[i];
            #(half);
            serial_clk_o = 1'b1;
            #(half);
            serial_clk_o = 1'b0;
        end
        #(half);
        // Select rises with the link clock low
        chip_sel_n_o = 1'b1;
        // Released data line must not keep its last value
        serial_in_o = ~serial_in_o;
        #40;
    endtask

    // Clock edges with select high, which the chain must ignore
    task automatic stray_clocks();
        for (int i = 0; i < 6; i++)
        begin
            serial_in_o = i[0];
            #3 serial_clk_o = 1'b1;
            #3 serial_clk_o = 1'b0;
        end
        #40;
    endtask
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the quad converter load control
`timescale 1ns/1ps
module tb_top;
    import qdlc_pkg::*;
    // ------------------------------------------------------------
    // Shared pins; both variants see the same nets
    // ------------------------------------------------------------
    logic clock_i, rst_i, ser_clk, cs_n, ser_in, write_n, load_n, clear_n;
    logic [SEL_W-1:0] psel; // Parallel channel address
    logic [CODE_W-1:0] bus;
    qdlc_bank_t dac_s, dac_p, exp;
    logic [NUM_CH-1:0] shut_s, shut_p;
    int miscompares, tests_run;
    logic [CODE_W-1:0] codes [NUM_CH] = '{8'hA5, 8'h3C, 8'hFF, 8'h01};

    qdlc_top #(.PARALLEL_VARIANT(1'b0)) qdlc_top_i (.clock_i(clock_i),
        .rst_i(rst_i), .serial_clk_i(ser_clk), .chip_sel_n_i(cs_n),
        .serial_in_i(ser_in), .write_n_i(write_n),
        .channel_sel_hi_i(psel[1]), .channel_sel_lo_i(psel[0]),
        .parallel_code_bus_i(bus), .dac_load_strobe_n_i(load_n),
        .clear_n_i(clear_n), .dac_code_o(dac_s), .shutdown_o(shut_s));
    // Parallel variant shares every pin, so serial traffic must not reach it
    qdlc_top #(.PARALLEL_VARIANT(1'b1)) qdlc_top_par_i (.clock_i(clock_i),
        .rst_i(rst_i), .serial_clk_i(ser_clk), .chip_sel_n_i(cs_n),
        .serial_in_i(ser_in), .write_n_i(write_n),
        .channel_sel_hi_i(psel[1]), .channel_sel_lo_i(psel[0]),
        .parallel_code_bus_i(bus), .dac_load_strobe_n_i(load_n),
        .clear_n_i(clear_n), .dac_code_o(dac_p), .shutdown_o(shut_p));
    qdlc_host_model qdlc_host_model_i (.serial_clk_o(ser_clk),
        .chip_sel_n_o(cs_n), .serial_in_o(ser_in));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(string name, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (e !== g)
        begin
            $display("MISMATCH %s expected %h seen %h", name, e, g);
            miscompares++;
        end
    endtask

    // Pin effects land three edges later; eight leaves margin
    task automatic wait_clk(int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic frame(logic [1:0] flags, logic [1:0] ch, logic [7:0] c);
        qdlc_host_model_i.send_frame({flags, ch, c}, FRAME_BITS, 3);
        wait_clk(8);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("dac_s", 0, dac_s);
        chk("shut_s", 0, shut_s);
        chk("dac_p", 0, dac_p);
        chk("shut_p", 0, shut_p);
    endtask

    task automatic t_serial();
        exp = '0;
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            frame(2'b11, ch[1:0], codes[ch]);
            exp[ch] = codes[ch];
        end
        chk("dac_s held", 0, dac_s);
        load_n = 1'b0;
        wait_clk(8);
        chk("dac_s load", exp, dac_s);
        // New frame while the load strobe stays low
        qdlc_host_model_i.send_frame({2'b11, CH_B, 8'h5A}, FRAME_BITS, 3);
        wait_clk(8);
        exp[1] = 8'h5A;
        chk("dac_s follow", exp, dac_s);
        chk("dac_p serial", 0, dac_p);
        load_n = 1'b1;
        wait_clk(8);
        frame(2'b11, CH_A, 8'h00);
        chk("dac_s frozen", exp, dac_s);
        qdlc_host_model_i.stray_clocks();
        qdlc_host_model_i.send_frame(12'h000, 0, 3);
        wait_clk(1);
        load_n = 1'b0;
        wait_clk(8);
        exp[0] = 8'h00;
        chk("dac_s stray", exp, dac_s);
        chk("shut_s none", 0, shut_s);
    endtask

    task automatic t_shutdown();
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            frame(2'b10, ch[1:0], 8'h10);
            chk("shut_s sel", 4'h1 << ch, shut_s);
        end
        frame(2'b01, CH_B, 8'h20);
        chk("shut_s all", SHUT_EVERY, shut_s);
        frame(2'b11, CH_D, 8'h77);
        chk("shut_s off", SHUT_NONE, shut_s);
        chk("shut_p frames", 0, shut_p);
    endtask

    task automatic t_clear();
        clear_n = 1'b0;
        wait_clk(8);
        chk("dac_s clr", 0, dac_s);
        chk("dac_p clr", 0, dac_p);
        clear_n = 1'b1;
        wait_clk(8);
        chk("dac_s after", 0, dac_s);
        // Chain survives the clear, so a bare select re-stores it
        qdlc_host_model_i.send_frame(12'h000, 0, 3);
        wait_clk(8);
        chk("dac_s chain", {8'h77, 24'h0}, dac_s);
    endtask

    task automatic t_parallel();
        load_n = 1'b1;
        exp = '0;
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            psel = ch[1:0];
            bus = codes[ch];
            write_n = 1'b0;
            wait_clk(6);
            write_n = 1'b1;
            wait_clk(6);
            bus = ~codes[ch];
            exp[ch] = codes[ch];
        end
        chk("dac_p held", 0, dac_p);
        load_n = 1'b0;
        wait_clk(8);
        chk("dac_p load", exp, dac_p);
        chk("dac_p wrhi", exp, dac_p);
        psel = CH_B;
        bus = 8'h99;
        write_n = 1'b0;
        wait_clk(8);
        exp[1] = 8'h99;
        chk("dac_p flow", exp, dac_p);
        write_n = 1'b1;
        wait_clk(6);
        load_n = 1'b1;
        wait_clk(6);
        bus = 8'h42;
        psel = CH_C;
        wait_clk(8);
        chk("dac_p idle", exp, dac_p);
        chk("dac_s par", {8'h77, 24'h0}, dac_s);
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // Cuts a hang short at 80000 cycles, well over the run length
    initial
    begin
        #400000;
        miscompares++;
        stop_test();
    end

    initial
    begin
        miscompares = 0;
        tests_run = 0;
        rst_i = 1'b1;
        write_n = 1'b1;
        load_n = 1'b1;
        clear_n = 1'b1;
        psel = CH_A;
        bus = 8'h00;
        repeat (16) @(negedge clock_i);
        rst_i = 1'b0;
        wait_clk(4);
        t_reset();
        t_serial();
        t_shutdown();
        t_clear();
        t_parallel();
        stop_test();
    end
endmodule
